// >>> tb/usbl_dev_model.sv
// downstream usb device model answering lpm token pairs
`timescale 1ns/1ns
module usbl_dev_model (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       tok,
	input  wire logic [2:0] mode,
	input  wire logic [3:0] dly,
	input  wire logic       wake,
	output logic            hs_valid,
	output logic [1:0]      hs_code,
	output logic            hs_bad,
	output logic            hs_timeout,
	output logic            k_pin
);
	logic       busy;
	logic [3:0] cnt;
	logic [7:0] free;
	// mode: 0 ack, 1 nyet, 2 stall, 3 corrupted, 4 silent; code lines churn when idle
	always_ff @(posedge clk) begin
		free <= srst ? 8'h00 : free + 8'h01;
		hs_valid <= 1'b0;
		hs_timeout <= 1'b0;
		hs_code <= free[1:0];
		hs_bad <= free[2];
		if (srst)
			busy <= 1'b0;
		else if (tok) begin
			busy <= 1'b1;
			cnt <= dly;
		end else if (busy && cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (busy) begin
			busy <= 1'b0;
			hs_timeout <= (mode == 3'h4);
			hs_valid <= (mode != 3'h4);
			hs_code <= (mode == 3'h3) ? usbl_pkg::HS_ACK : mode[1:0];
			hs_bad <= (mode == 3'h3);
		end
	end
	always_ff @(posedge clk) k_pin <= !srst && wake;
endmodule : usbl_dev_model

// >>> tb/usbl_lpm_ctrl_asserts.sv
// port-level concurrent checks for the lpm l1 host control
`timescale 1ns/1ns
module usbl_lpm_ctrl_asserts #(
	parameter int L1_MIN_CYCLES = 8
) (
	input wire logic       CLK_SYS,
	input wire logic       SRST,
	input wire logic       WB_CYC_I,
	input wire logic       WB_STB_I,
	input wire logic       WB_ACK_O,
	input wire logic       HS_VALID,
	input wire logic [1:0] HS_CODE,
	input wire logic       HS_BAD,
	input wire logic       HS_TIMEOUT,
	input wire logic       TOK_SEND,
	input wire logic       K_DRIVE,
	input wire logic       SOF_EN
);
	logic [15:0] slp;
	// counts cycles with frame generation off; saturates so a long sleep never wraps
	always_ff @(posedge CLK_SYS) begin
		if (SRST || SOF_EN)
			slp <= 16'h0000;
		else if (slp != 16'hFFFF)
			slp <= slp + 16'h0001;
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("bus ack longer than one cycle");
	AST_ACK_RESP: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
		else $error("bus ack late");
	AST_TOK_GAP: assert property (TOK_SEND |=> !TOK_SEND [*3])
		else $error("token pair too close");
	AST_SOF_OFF: assert property ((HS_VALID && !HS_BAD && HS_CODE == usbl_pkg::HS_ACK)
		|-> ##[1:3] !SOF_EN)
		else $error("frames not stopped after ack");
	AST_NYET_AWAKE: assert property ((HS_VALID && !HS_BAD && HS_CODE == usbl_pkg::HS_NYET)
		|=> SOF_EN [*3])
		else $error("sleep entered after nyet");
	AST_SLEEP_NO_TOK: assert property (!SOF_EN |-> !TOK_SEND)
		else $error("token sent while asleep");
	AST_RESID: assert property ($rose(K_DRIVE) |-> slp >= L1_MIN_CYCLES)
		else $error("resume before residency");
	AST_K_LEN: assert property ($rose(K_DRIVE) |-> !SOF_EN ##1 K_DRIVE [*4])
		else $error("resume k too short");
	AST_SOF_BACK: assert property ($fell(K_DRIVE) |-> ##[0:2] SOF_EN)
		else $error("frames not restarted");
	cover property (TOK_SEND);
	cover property (HS_TIMEOUT ##[1:8] TOK_SEND);
	cover property ($fell(K_DRIVE));
endmodule : usbl_lpm_ctrl_asserts
bind usbl_lpm_ctrl usbl_lpm_ctrl_asserts #(.L1_MIN_CYCLES(L1_MIN_CYCLES)) u_chk (
	.CLK_SYS(CLK_SYS), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_ACK_O(WB_ACK_O), .HS_VALID(HS_VALID), .HS_CODE(HS_CODE), .HS_BAD(HS_BAD),
	.HS_TIMEOUT(HS_TIMEOUT), .TOK_SEND(TOK_SEND), .K_DRIVE(K_DRIVE), .SOF_EN(SOF_EN));

// >>> tb/usbl_lpm_ctrl_tb.sv
// self-checking bench for the lpm l1 host control
`timescale 1ns/1ns
module usbl_lpm_ctrl_tb;
	localparam int PR = 20;
	localparam int PB = 4;
	localparam int PL = 8;
	logic        clk, srst, cyc, stb, we, ack, hv, hb, ht, kp, tok, kd, sof, irq, wake;
	logic [8:0]  adr;
	logic [3:0]  sel, dly;
	logic [31:0] di, dq, q;
	logic [1:0]  hc;
	logic [10:0] attr;
	logic [2:0]  mode;
	int          err_total, cmp_count, tok_n, n, v, c, besl;
	int          ep_m [8];
	usbl_lpm_ctrl #(.RESUME_CYCLES(PR), .BESL_CYCLES(PB), .L1_MIN_CYCLES(PL)) dut (
		.CLK_SYS(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(di), .WB_DAT_O(dq), .WB_ACK_O(ack),
		.HS_VALID(hv), .HS_CODE(hc), .HS_BAD(hb), .HS_TIMEOUT(ht), .UPSTREAM_K_PIN(kp),
		.TOK_SEND(tok), .LPM_ATTR(attr), .K_DRIVE(kd), .SOF_EN(sof), .IRQ(irq));
	usbl_dev_model u_dev (.clk(clk), .srst(srst), .tok(tok), .mode(mode), .dly(dly),
		.wake(wake), .hs_valid(hv), .hs_code(hc), .hs_bad(hb), .hs_timeout(ht), .k_pin(kp));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (tok === 1'b1) tok_n++;
	task finish_test;
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task fail_to;
		err_total++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		finish_test;
	endtask : fail_to
	initial begin
		repeat (60000) @(posedge clk);
		fail_to;
	end
	// classic single cycle; ack and read data are taken at the same edge
	task wb(input logic w, input logic [8:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; di <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) fail_to;
		q = dq;
		cyc <= 1'b0; stb <= 1'b0;
	endtask : wb
	task automatic wait_hi(ref logic s, input int lim);
		int k;
		k = 0;
		while (s !== 1'b1 && k < lim) begin
			@(posedge clk);
			k++;
		end
		if (k >= lim) fail_to;
	endtask : wait_hi
	task k_len(input logic [8:0] bitv, input int e);
		wb(1'b1, usbl_pkg::IDX_CTRL, 32'h1 << bitv);
		wait_hi(kd, 20);
		n = 0;
		while (kd === 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		chk(n, e);
		repeat (2) @(posedge clk);
		chk(sof, 1'b1);
		wb(1'b0, usbl_pkg::IDX_CTRL, 32'h0);
		chk(q, 32'h1);
	endtask : k_len
	task run(input logic [2:0] m, input int mx);
		int fb;
		fb = (m == 3'h0) ? usbl_pkg::INT_TRANSFER_COMPLETE_0_FLAG : (m == 3'h1) ? usbl_pkg::INT_TRANSFER_FAIL_FLAG :
			(m == 3'h2) ? usbl_pkg::INT_STALL : usbl_pkg::INT_PIPE_ERROR_FLAG;
		mode <= m;
		dly <= 4'($urandom_range(0, 15));
		tok_n = 0;
		wb(1'b1, usbl_pkg::IDX_PIPE_CFG, 32'((mx << usbl_pkg::CFG_MAXERR_LSB) | 1 |
			(usbl_pkg::PIPE_TYPE_EXTENDED << usbl_pkg::CFG_TYPE_LSB)));
		wait_hi(irq, 400);
		wb(1'b1, usbl_pkg::IDX_PIPE_CFG, 32'h0);
		chk(tok_n, (m > 3'h2) ? mx + 1 : 1);
		wb(1'b0, usbl_pkg::IDX_INT_FLAGS, 32'h0);
		chk(q, 32'h1 << fb);
		wb(1'b0, usbl_pkg::IDX_PIPE_STATE, 32'h0);
		chk(q, (m > 3'h2) ? ((usbl_pkg::BANK_STATUS_FAIL << usbl_pkg::PST_BANK_LSB) |
			(mx << usbl_pkg::PST_ERRCNT_LSB) | 1) : 1);
		wb(1'b0, usbl_pkg::IDX_SUMMARY, 32'h0);
		chk(q, 32'h1);
		wb(1'b1, usbl_pkg::IDX_INT_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wb(1'b1, usbl_pkg::IDX_INT_MASK, 32'h1F);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		wb(1'b1, usbl_pkg::IDX_INT_FLAGS, 32'h1F);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wb(1'b1, usbl_pkg::IDX_PIPE_STATE, 32'h1);
		wb(1'b0, usbl_pkg::IDX_PIPE_STATE, 32'h0);
		chk(q, 32'h0);
	endtask : run
	initial begin
		srst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 9'h000; di = 32'h0;
		sel = 4'hF; mode = 3'h0; dly = 4'h0; wake = 1'b0;
		void'($urandom(32'hf2c0e24e));
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		wb(1'b0, usbl_pkg::IDX_CTRL, 32'h0);
		chk(q, 32'(usbl_pkg::CTRL_RESET));
		chk(sof, 1'b1);
		wb(1'b1, 9'h0FF, $urandom);
		wb(1'b0, 9'h0FF, 32'h0);
		chk(q, 32'h0);
		for (int e = 0; e < usbl_pkg::IDX_EP_STRIDE / 4; e++) begin
			v = $urandom;
			c = $urandom;
			wb(1'b0, 9'(usbl_pkg::IDX_EP_STATE + e * usbl_pkg::IDX_EP_STRIDE), 32'h0);
			chk(q, 32'(usbl_pkg::EP_RESET));
			wb(1'b1, 9'(usbl_pkg::IDX_EP_SET + e * usbl_pkg::IDX_EP_STRIDE), v);
			ep_m[e] = v & 8'hF7;
			wb(1'b0, 9'(usbl_pkg::IDX_EP_STATE + e * usbl_pkg::IDX_EP_STRIDE), 32'h0);
			chk(q, ep_m[e]);
			wb(1'b1, 9'(usbl_pkg::IDX_EP_CLR + e * usbl_pkg::IDX_EP_STRIDE), c);
			ep_m[e] = ep_m[e] & ~c;
			wb(1'b0, 9'(usbl_pkg::IDX_EP_STATE + e * usbl_pkg::IDX_EP_STRIDE), 32'h0);
			chk(q, ep_m[e]);
		end
		wb(1'b1, usbl_pkg::IDX_INT_MASK, 32'h1F);
		for (int m = 1; m < 5; m++) run(3'(m), $urandom_range(0, 3));
		besl = $urandom_range(0, 3);
		wb(1'b1, usbl_pkg::IDX_EXT_WORD, besl << usbl_pkg::EXT_BESL_LSB);
		// the word lands at the ack edge and the output flop follows one edge later
		repeat (2) @(posedge clk);
		chk(attr, 11'(besl << usbl_pkg::EXT_BESL_LSB));
		run(3'h0, $urandom_range(0, 15));
		chk(sof, 1'b0);
		wake <= 1'b1;
		wait_hi(irq, 20);
		wake <= 1'b0;
		wb(1'b0, usbl_pkg::IDX_INT_FLAGS, 32'h0);
		chk(q, 32'h1 << usbl_pkg::INT_UPWAKE);
		wb(1'b1, usbl_pkg::IDX_INT_FLAGS, 32'h1F);
		repeat (PL) @(posedge clk);
		k_len(usbl_pkg::CTRL_L1WAKE_BIT, PB * (besl + 1) + 1);
		run(3'h0, 1);
		repeat (PL) @(posedge clk);
		k_len(usbl_pkg::CTRL_RESUME_BIT, PR + 1);
		finish_test;
	end
endmodule : usbl_lpm_ctrl_tb

// >>> verilog/usbl_lpm_ctrl.sv
// lpm l1 host control with wishbone register slave and endpoint state strobes
`timescale 1ns/1ns
module usbl_lpm_ctrl #(
	parameter int NUM_EP        = 8,
	parameter int RESUME_CYCLES = usbl_pkg::DN_RESUME_CYC,
	parameter int BESL_CYCLES   = usbl_pkg::BESL_UNIT_CYC,
	parameter int L1_MIN_CYCLES = usbl_pkg::L1_RESIDENCY_CYC
) (
	input  wire logic        CLK_SYS,
	input  wire logic        SRST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [10:2] WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        HS_VALID,
	input  wire logic [1:0]  HS_CODE,
	input  wire logic        HS_BAD,
	input  wire logic        HS_TIMEOUT,
	input  wire logic        UPSTREAM_K_PIN,
	output logic             TOK_SEND,
	output logic      [10:0] LPM_ATTR,
	output logic             K_DRIVE,
	output logic             SOF_EN,
	output logic             IRQ
);
	logic                    ack;
	logic             [31:0] rdata;
	logic              [2:0] ctrl;
	logic              [7:0] cfg;
	logic             [10:0] ext_word;
	logic                    freeze;
	logic              [3:0] error_counter;
	logic              [1:0] bank_status_field;
	logic              [4:0] int_flags;
	logic              [4:0] int_mask;
	logic              [7:0] endpoint_state [NUM_EP];
	logic                    up_meta;
	logic                    up_sync;
	logic                    up_prev;
	logic             [31:0] timer;
	logic                    resid_done;
	logic                    tok_send;
	logic                    k_drive;
	logic                    l1_kind;
	usbl_pkg::usbl_state_t   state;
	logic                    wr;
	logic             [31:0] wd;
	logic              [8:0] idx;
	logic                    up_edge;
	logic                    ev_ack;
	logic                    ev_nyet;
	logic                    ev_stall;
	logic                    ev_pipe_error_flag;
	logic                    ev_retry;
	logic                    ev_sleep_exit;
	logic                    start;
	logic              [3:0] besl;

	// byte lane masking of write data
	function automatic logic [31:0] lane_mask(input logic [31:0] d, input logic [3:0] sel);
		lane_mask = d & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	// true when idx addresses endpoint n at base b
	function automatic logic ep_hit(input logic [8:0] i, input logic [8:0] b, input int n);
		ep_hit = (i == 9'(b + 9'(n) * usbl_pkg::IDX_EP_STRIDE));
	endfunction : ep_hit

	assign idx = WB_ADR_I;
	// write takes effect only at the edge where the master sees ack
	assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ack;
	assign wd = lane_mask(WB_DAT_I, WB_SEL_I);
	assign up_edge = up_sync & ~up_prev;
	assign besl = ext_word[usbl_pkg::EXT_BESL_LSB +: 4];

	// classic single-cycle slave: ack one cycle after the strobe, dropped the next
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ack <= 1'b0;
		end else begin
			ack <= WB_CYC_I & WB_STB_I & ~ack;
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		case (idx)
			usbl_pkg::IDX_CTRL: rdata[2:0] = ctrl;
			usbl_pkg::IDX_PIPE_CFG: rdata[7:0] = cfg;
			usbl_pkg::IDX_EXT_WORD: rdata[10:0] = ext_word;
			usbl_pkg::IDX_PIPE_STATE: begin
				rdata[usbl_pkg::PST_FREEZE_BIT] = freeze;
				rdata[usbl_pkg::PST_ERRCNT_LSB +: 4] = error_counter;
				rdata[usbl_pkg::PST_BANK_LSB +: 2] = bank_status_field;
			end
			usbl_pkg::IDX_INT_FLAGS: rdata[4:0] = int_flags;
			usbl_pkg::IDX_INT_MASK: rdata[4:0] = int_mask;
			usbl_pkg::IDX_SUMMARY: rdata[0] = |int_flags; // [R18]
			default: begin
				for (int n = 0; n < NUM_EP; n++) begin
					if (ep_hit(idx, usbl_pkg::IDX_EP_STATE, n)) begin
						rdata[7:0] = endpoint_state[n];
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			WB_DAT_O <= 32'h0000_0000;
		end else if (WB_CYC_I & WB_STB_I & ~WB_WE_I & ~ack) begin
			WB_DAT_O <= rdata;
		end
	end

	assign WB_ACK_O = ack;

	// upstream k from the line is asynchronous
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			up_meta <= 1'b0;
			up_sync <= 1'b0;
			up_prev <= 1'b0;
		end else begin
			up_meta <= UPSTREAM_K_PIN;
			up_sync <= up_meta;
			up_prev <= up_sync;
		end
	end

	// pipe config and extended word; token, bank and size beyond the type are unused
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			cfg <= usbl_pkg::CFG_RESET;
			ext_word <= usbl_pkg::EXT_RESET;
		end else if (wr) begin
			if (idx == usbl_pkg::IDX_PIPE_CFG) begin
				cfg <= wd[7:0]; // [R1]
			end
			if (idx == usbl_pkg::IDX_EXT_WORD) begin
				ext_word <= wd[10:0]; // [R1]
			end
		end
	end

	assign start = (state == usbl_pkg::ST_IDLE) & cfg[usbl_pkg::CFG_ENABLE_BIT] & ~freeze
		& (cfg[usbl_pkg::CFG_TYPE_LSB +: 3] == usbl_pkg::PIPE_TYPE_EXTENDED); // [R2] [R9]

	assign ev_ack = (state == usbl_pkg::ST_WAIT) & HS_VALID & ~HS_BAD
		& (HS_CODE == usbl_pkg::HS_ACK);
	assign ev_nyet = (state == usbl_pkg::ST_WAIT) & HS_VALID & ~HS_BAD
		& (HS_CODE == usbl_pkg::HS_NYET);
	assign ev_stall = (state == usbl_pkg::ST_WAIT) & HS_VALID & ~HS_BAD
		& (HS_CODE == usbl_pkg::HS_STALL);
	// a corrupted or absent handshake counts as an error of the transaction
	assign ev_retry = (state == usbl_pkg::ST_WAIT) & ((HS_VALID & HS_BAD) | HS_TIMEOUT)
		& (error_counter < cfg[usbl_pkg::CFG_MAXERR_LSB +: 4]); // [R7] [R17]
	assign ev_pipe_error_flag = (state == usbl_pkg::ST_WAIT) & ((HS_VALID & HS_BAD) | HS_TIMEOUT)
		& (error_counter >= cfg[usbl_pkg::CFG_MAXERR_LSB +: 4]); // [R8]
	assign ev_sleep_exit = (state == usbl_pkg::ST_RESUME) & (timer == 32'h0000_0000);

	// transaction and sleep sequencing
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			state <= usbl_pkg::ST_IDLE;
			timer <= 32'h0000_0000;
			resid_done <= 1'b0;
			tok_send <= 1'b0;
			k_drive <= 1'b0;
			l1_kind <= 1'b0;
		end else begin
			tok_send <= 1'b0;
			case (state)
				usbl_pkg::ST_IDLE: begin
					if (start) begin
						state <= usbl_pkg::ST_SEND;
					end
				end
				usbl_pkg::ST_SEND: begin
					tok_send <= 1'b1; // [R2]
					state <= usbl_pkg::ST_WAIT;
				end
				usbl_pkg::ST_WAIT: begin
					if (ev_ack) begin
						state <= usbl_pkg::ST_SLEEP; // [R3]
						timer <= 32'(L1_MIN_CYCLES);
						resid_done <= 1'b0;
					end else if (ev_retry) begin
						state <= usbl_pkg::ST_SEND; // [R7]
					end else if (ev_nyet | ev_stall | ev_pipe_error_flag) begin
						state <= usbl_pkg::ST_IDLE; // [R5]
					end
				end
				usbl_pkg::ST_SLEEP: begin
					// a resume request waits until the minimum residency has passed
					if (timer != 32'h0000_0000) begin
						timer <= timer - 32'h0000_0001; // [R3]
					end else begin
						resid_done <= 1'b1;
					end
					if (resid_done & (ctrl[usbl_pkg::CTRL_RESUME_BIT] | ctrl[usbl_pkg::CTRL_L1WAKE_BIT])) begin
						state <= usbl_pkg::ST_RESUME; // [R10]
						k_drive <= 1'b1;
						l1_kind <= ctrl[usbl_pkg::CTRL_L1WAKE_BIT];
						if (ctrl[usbl_pkg::CTRL_L1WAKE_BIT]) begin
							timer <= 32'(BESL_CYCLES) * (32'(besl) + 32'h0000_0001); // [R11]
						end else begin
							timer <= 32'(RESUME_CYCLES); // [R10]
						end
					end
				end
				usbl_pkg::ST_RESUME: begin
					if (timer != 32'h0000_0000) begin
						timer <= timer - 32'h0000_0001; // [R11]
					end else begin
						k_drive <= 1'b0;
						state <= usbl_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= usbl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// host control b: hardware owns sof enable across sleep, resume bits end with the k state
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ctrl <= usbl_pkg::CTRL_RESET;
		end else begin
			if (wr & (idx == usbl_pkg::IDX_CTRL)) begin
				ctrl <= wd[2:0]; // [R10]
			end
			if (ev_ack) begin
				ctrl[usbl_pkg::CTRL_SOF_BIT] <= 1'b0; // [R4]
			end
			if (ev_sleep_exit) begin
				ctrl[usbl_pkg::CTRL_SOF_BIT] <= 1'b1; // [R13]
				ctrl[usbl_pkg::CTRL_RESUME_BIT] <= 1'b0;
				ctrl[usbl_pkg::CTRL_L1WAKE_BIT] <= 1'b0;
			end
		end
	end

	// pipe state: writing one to the freeze bit unfreezes; a freeze event wins
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			freeze <= 1'b0;
			error_counter <= 4'h0;
			bank_status_field <= 2'h0;
		end else begin
			if (wr & (idx == usbl_pkg::IDX_PIPE_STATE)) begin
				if (wd[usbl_pkg::PST_FREEZE_BIT]) begin
					freeze <= 1'b0; // [R9]
				end
				error_counter <= wd[usbl_pkg::PST_ERRCNT_LSB +: 4];
				bank_status_field <= wd[usbl_pkg::PST_BANK_LSB +: 2];
			end
			if (start) begin
				error_counter <= 4'h0;
			end
			if (ev_retry) begin
				error_counter <= error_counter + 4'h1; // [R17]
			end
			if (ev_pipe_error_flag) begin
				bank_status_field <= usbl_pkg::BANK_STATUS_FAIL; // [R8]
			end
			if (ev_ack | ev_nyet | ev_stall | ev_pipe_error_flag) begin
				freeze <= 1'b1; // [R9]
			end
		end
	end

	// sticky flags, write one to clear, a new event in the same cycle wins
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			int_flags <= usbl_pkg::INT_RESET;
			int_mask <= usbl_pkg::INT_RESET;
		end else begin
			if (wr & (idx == usbl_pkg::IDX_INT_MASK)) begin
				int_mask <= wd[4:0];
			end
			int_flags <= (int_flags & ~((wr & (idx == usbl_pkg::IDX_INT_FLAGS)) ? wd[4:0] : 5'h00))
				| ({4'h0, ev_ack} << usbl_pkg::INT_TRANSFER_COMPLETE_0_FLAG) // [R3]
				| ({4'h0, ev_nyet} << usbl_pkg::INT_TRANSFER_FAIL_FLAG) // [R5]
				| ({4'h0, ev_pipe_error_flag} << usbl_pkg::INT_PIPE_ERROR_FLAG) // [R8]
				| ({4'h0, ev_stall} << usbl_pkg::INT_STALL) // [R6]
				| ({4'h0, up_edge & (state == usbl_pkg::ST_SLEEP)} << usbl_pkg::INT_UPWAKE); // [R12]
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(int_flags & int_mask); // [R18]
		end
	end

	// endpoint state with clear and set strobes; bit 3 does not exist
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			for (int n = 0; n < NUM_EP; n++) begin
				endpoint_state[n] <= usbl_pkg::EP_RESET; // [R15]
			end
		end else if (wr) begin
			for (int n = 0; n < NUM_EP; n++) begin
				if (ep_hit(idx, usbl_pkg::IDX_EP_CLR, n)) begin
					endpoint_state[n] <= endpoint_state[n] & ~(wd[7:0] & usbl_pkg::EP_FIELD_MASK); // [R14]
				end
				if (ep_hit(idx, usbl_pkg::IDX_EP_SET, n)) begin
					endpoint_state[n] <= endpoint_state[n] | (wd[7:0] & usbl_pkg::EP_FIELD_MASK); // [R15] [R16]
				end
			end
		end
	end

	// link-facing outputs all from flops
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			TOK_SEND <= 1'b0;
			LPM_ATTR <= usbl_pkg::EXT_RESET;
			K_DRIVE <= 1'b0;
			SOF_EN <= 1'b0;
		end else begin
			TOK_SEND <= tok_send;
			LPM_ATTR <= ext_word;
			K_DRIVE <= k_drive;
			SOF_EN <= ctrl[usbl_pkg::CTRL_SOF_BIT];
		end
	end
endmodule : usbl_lpm_ctrl

// >>> verilog/usbl_pkg.sv
// shared constants for the lpm l1 host control block
// Functional notes
// R1 - software marks pipe extended and fills lpm attributes; token/bank/size are ignored
// R2 - enabled extended pipe sends extended token then lpm token, awaits answer
// R3 - ack enters l1 sleep at once, sets transfer complete 0, minimum residency
// R4 - entering l1 sleep clears start-of-frame generation enable
// R5 - nyet sets transfer fail flag and sleep is not entered
// R6 - stall handshake sets the stall flag
// R7 - missing or corrupted handshake resends token pair until max error number
// R8 - last failed retry sets pipe error flag and writes bank status field
// R9 - ack, nyet, stall or pipe error freezes pipe; software unfreezes
// R10 - downstream resume or l1 wakeup bit drives matching resume signalling
// R11 - l1 resume holds k state for time from best effort latency field
// R12 - upstream resume during l1 sleep sets upstream wakeup flag
// R13 - leaving l1 sleep sets start-of-frame generation enable again
// R14 - clear strobe: writing one clears matching endpoint state bit, zero no effect
// R15 - set strobe at index 0x105 plus n times 0x20, resets to zero
// R16 - writing one to set strobe sets matching endpoint state bit
// R17 - error below max error number increments error counter, no pipe error
// R18 - pipe error raises interrupt; summary register shows the pipe
package usbl_pkg;
	// register indices; byte address is four times the index
	localparam logic [8:0] IDX_CTRL       = 9'h000;
	localparam logic [8:0] IDX_PIPE_CFG   = 9'h001;
	localparam logic [8:0] IDX_EXT_WORD   = 9'h002;
	localparam logic [8:0] IDX_PIPE_STATE = 9'h003;
	localparam logic [8:0] IDX_INT_FLAGS  = 9'h004;
	localparam logic [8:0] IDX_INT_MASK   = 9'h005;
	localparam logic [8:0] IDX_SUMMARY    = 9'h006;
	localparam logic [8:0] IDX_EP_CLR     = 9'h104;
	localparam logic [8:0] IDX_EP_SET     = 9'h105;
	localparam logic [8:0] IDX_EP_STATE   = 9'h106;
	localparam logic [8:0] IDX_EP_STRIDE  = 9'h020;
	// host control b fields
	localparam int CTRL_SOF_BIT     = 0;
	localparam int CTRL_RESUME_BIT  = 1;
	localparam int CTRL_L1WAKE_BIT  = 2;
	localparam logic [2:0] CTRL_RESET = 3'h1;
	// pipe config fields
	localparam int CFG_ENABLE_BIT  = 0;
	localparam int CFG_TYPE_LSB    = 1;
	localparam int CFG_MAXERR_LSB  = 4;
	localparam logic [2:0] PIPE_TYPE_EXTENDED = 3'h5;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// extended descriptor word: best effort latency nibble position
	localparam int EXT_BESL_LSB = 4;
	localparam logic [10:0] EXT_RESET = 11'h000;
	// pipe state fields
	localparam int PST_FREEZE_BIT = 0;
	localparam int PST_ERRCNT_LSB = 1;
	localparam int PST_BANK_LSB   = 5;
	// interrupt flag bits
	localparam int INT_TRANSFER_COMPLETE_0_FLAG = 0;
	localparam int INT_TRANSFER_FAIL_FLAG = 1;
	localparam int INT_PIPE_ERROR_FLAG = 2;
	localparam int INT_STALL = 3;
	localparam int INT_UPWAKE = 4;
	localparam logic [4:0] INT_RESET = 5'h00;
	localparam logic [7:0] EP_RESET = 8'h00;
	localparam logic [7:0] EP_FIELD_MASK = 8'hF7;
	// handshake codes from the packet engine
	localparam logic [1:0] HS_ACK   = 2'h0;
	localparam logic [1:0] HS_NYET  = 2'h1;
	localparam logic [1:0] HS_STALL = 2'h2;
	// bank status value written after exhausted retries
	localparam logic [1:0] BANK_STATUS_FAIL = 2'h3;
	// timing
	localparam int CLK_MHZ = 20;
	localparam int L1_RESIDENCY_US = 50;
	localparam int L1_RESIDENCY_CYC = L1_RESIDENCY_US * CLK_MHZ;
	localparam int BESL_UNIT_US = 75;
	localparam int BESL_UNIT_CYC = BESL_UNIT_US * CLK_MHZ;
	localparam int DN_RESUME_US = 20000;
	localparam int DN_RESUME_CYC = DN_RESUME_US * CLK_MHZ;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEND,
		ST_WAIT,
		ST_SLEEP,
		ST_RESUME
	} usbl_state_t;
endpackage : usbl_pkg
